// File: hw/lps_top.sv
// Bus physical-layer supervisor with AHB-Lite register slave
// Function
// - Events reported in flags, cleared writing one
// - Sleep or standby: transmitter off, receiver watches
// - Mode 0: fall plus long dominant wakes
// - Mode 1: fall, long dominant, then rise
// - Wake sets wake flag, enables transmitter
// - Fast baud bit selects fast mode
// - Debounced short sets flag, disables transmitter
// - Short needs overcurrent and dominant-versus-recessive mismatch
// - Debounce select: 96/128/192/255 divided-oscillator cycles
// - Own dominant beyond timeout: flag, power down
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module lps_top
	import lps_pkg::*;
#(
	parameter int unsigned WAKE_CYC = WAKE_MIN_CYC,
	parameter int unsigned DTO_LIM  = DTO_CYC
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Bus pins and transceiver
	input  wire logic        bus_rx,
	input  wire logic        tx_data,
	input  wire logic        tx_overcurrent,
	output logic             tx_out,
	output logic             tx_power_en,
	output logic             fast_baud_en,
	// System mode and interrupt
	input  wire logic        sleep_req,
	output logic             irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		lps_ctrl_t    ctrl;
		lps_flags_t   flags;
		lps_flags_t   irq_stat;
		lps_flags_t   irq_mask;
		lps_wake_st_t wake_st;
		logic         rx_prev;
		logic         sleep_prev;
		logic         wake_tx;
		logic         tx_out;
		logic         tx_pwr;
		logic [2:0]   div;
		logic         dp_wr;
		logic [7:0]   dp_idx;
		logic [31:0]  rdata;
	} lps_state_t;

	lps_state_t st_r;
	lps_state_t st_nxt;

	logic [SYNC_W-1:0] pins;
	logic              rx;
	logic              txd;
	logic              oc;
	logic              wake_exp;
	logic              short_exp;
	logic              dto_exp;
	logic              short_run;
	logic              dto_run;
	logic              wake_run;
	logic              osc_tick;
	logic [CNT_W-1:0]  db_limit;
	logic [CNT_W-1:0]  wake_limit;
	logic [CNT_W-1:0]  dto_limit;
	logic              ap_take;
	logic              ap_map;
	logic              ev_wake;
	lps_flags_t        set_ev;
	lps_flags_t        wr_clr;
	lps_flags_t        rd_clr;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	lps_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     ({tx_overcurrent, tx_data, bus_rx}),
		.dout    (pins)
	);

	// Bit order of the synchroniser word follows the package indices
	assign rx  = pins[SY_RX];
	assign txd = pins[SY_TX];
	assign oc  = pins[SY_OC];

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	// Wake and timeout timers count every clock; only the short timer uses the slow tick
	assign wake_limit = WAKE_CYC[CNT_W-1:0];
	assign dto_limit  = DTO_LIM[CNT_W-1:0];
	assign osc_tick   = (st_r.div == OSC_DIV_LAST);

	// Debounce length in divided-oscillator ticks
	always_comb begin
		unique case (st_r.ctrl.short_debounce_sel)
			2'h0: db_limit = DB_CYC_0;
			2'h1: db_limit = DB_CYC_1;
			2'h2: db_limit = DB_CYC_2;
			2'h3: db_limit = DB_CYC_3;
		endcase
	end

	// Dominant is low on the wire; rx is the real bus level
	assign wake_run  = (st_r.wake_st == WK_DOM) && !rx;
	assign short_run = st_r.tx_pwr && !st_r.tx_out && rx && oc;
	assign dto_run   = !st_r.tx_out;

	lps_timer u_wake_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (wake_run),
		.tick    (1'b1),
		.limit   (wake_limit),
		.expired (wake_exp)
	);

	lps_timer u_short_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (short_run),
		.tick    (osc_tick),
		.limit   (db_limit),
		.expired (short_exp)
	);

	lps_timer u_dto_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (dto_run),
		.tick    (1'b1),
		.limit   (dto_limit),
		.expired (dto_exp)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Zero-wait slave: every transfer is taken in its address phase
	assign ap_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
	// Upper bits must be zero and the word aligned, else the access is ignored
	assign ap_map  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt  = st_r;
		ev_wake = 1'b0;
		wr_clr  = '0;
		rd_clr  = '0;

		// Divider for the slow debounce tick
		st_nxt.div = osc_tick ? 3'h0 : st_r.div + 3'h1;
		st_nxt.rx_prev    = rx;
		st_nxt.sleep_prev = sleep_req;

		// Wake watcher runs only while asleep and not yet woken
		if (!sleep_req || st_r.wake_tx) begin
			st_nxt.wake_st = WK_IDLE;
		end else begin
			unique case (st_r.wake_st)
				WK_IDLE: begin
					if (st_r.rx_prev && !rx) begin
						st_nxt.wake_st = WK_DOM;
					end
				end
				WK_DOM: begin
					if (rx) begin
						st_nxt.wake_st = WK_IDLE;
					end else if (wake_exp) begin
						if (st_r.ctrl.bus_wake_mode_sel) begin
							st_nxt.wake_st = WK_RISE;
						end else begin
							ev_wake        = 1'b1;
							st_nxt.wake_st = WK_IDLE;
						end
					end
				end
				WK_RISE: begin
					if (rx) begin
						ev_wake        = 1'b1;
						st_nxt.wake_st = WK_IDLE;
					end
				end
			endcase
		end

		// Woken transmitter stays on until the next entry into sleep
		if (ev_wake) begin
			st_nxt.wake_tx = 1'b1;
		end else if (sleep_req && !st_r.sleep_prev) begin
			st_nxt.wake_tx = 1'b0;
		end

		// Data phase of a write: control store and flag clears
		if (st_r.dp_wr) begin
			if (st_r.dp_idx == CTRL_IDX) begin
				st_nxt.ctrl = hwdata[3:0];
			end
			if (st_r.dp_idx == STAT_IDX) begin
				wr_clr = hwdata[2:0];
			end
			if (st_r.dp_idx == IRQ_MASK_IDX) begin
				st_nxt.irq_mask = hwdata[2:0];
			end
		end

		// Address phase: latch writes, prepare read data
		st_nxt.dp_wr = 1'b0;
		if (ap_take) begin
			st_nxt.dp_wr  = hwrite && ap_map;
			st_nxt.dp_idx = haddr[9:2];
			st_nxt.rdata  = 32'h00000000;
			if (!hwrite && ap_map) begin
				unique case (haddr[9:2])
					CTRL_IDX:     st_nxt.rdata[3:0] = st_r.ctrl;
					STAT_IDX:     st_nxt.rdata[2:0] = st_r.flags;
					IRQ_STAT_IDX: begin
						st_nxt.rdata[2:0] = st_r.irq_stat;
						rd_clr            = 3'h7;
					end
					IRQ_MASK_IDX: st_nxt.rdata[2:0] = st_r.irq_mask;
					default:      st_nxt.rdata = 32'h00000000;
				endcase
			end
		end

		// Detector events; a set in the clearing cycle wins
		set_ev.bus_wake_flag         = ev_wake;
		set_ev.bus_short_flag        = short_exp;
		set_ev.dominant_timeout_flag = dto_exp;
		st_nxt.flags    = (st_r.flags & ~wr_clr) | set_ev;
		st_nxt.irq_stat = (st_r.irq_stat & ~rd_clr) | (set_ev & ~st_r.flags);

		// Transmitter power: off in sleep unless woken, off on faults
		st_nxt.tx_pwr = (!sleep_req || st_nxt.wake_tx)
			&& !st_nxt.flags.bus_short_flag
			&& !st_nxt.flags.dominant_timeout_flag;
		// Unpowered driver releases the bus to recessive
		st_nxt.tx_out = st_nxt.tx_pwr ? txd : 1'b1;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '{
				ctrl:       CTRL_RST,
				flags:      FLAG_RST,
				irq_stat:   FLAG_RST,
				irq_mask:   FLAG_RST,
				wake_st:    WK_IDLE,
				rx_prev:    1'b1,
				sleep_prev: 1'b0,
				wake_tx:    1'b0,
				tx_out:     1'b1,
				tx_pwr:     1'b0,
				div:        3'h0,
				dp_wr:      1'b0,
				dp_idx:     8'h00,
				rdata:      32'h00000000
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata       = st_r.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign tx_out       = st_r.tx_out;
	assign tx_power_en  = st_r.tx_pwr;
	assign fast_baud_en = st_r.ctrl.fast_baud_en;
	// Level interrupt while any unmasked sticky bit stands
	assign irq          = |(st_r.irq_stat & st_r.irq_mask);

endmodule : lps_top

// File: hw/lps_pkg.sv
// Package of constants and types for the bus physical-layer supervisor
package lps_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS       = 8;
	localparam int unsigned WAKE_MIN_US  = 100;
	localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DTO_MS       = 11;
	localparam int unsigned DTO_CYC      = (DTO_MS * 1000000) / CLK_NS;
	localparam logic [2:0]  OSC_DIV_LAST = 3'h4;   // Divide by five: 0..4
	localparam int          CNT_W        = 21;
	localparam logic [CNT_W-1:0] DB_CYC_0 = 21'h000060;   // 96
	localparam logic [CNT_W-1:0] DB_CYC_1 = 21'h000080;   // 128
	localparam logic [CNT_W-1:0] DB_CYC_2 = 21'h0000c0;   // 192
	localparam logic [CNT_W-1:0] DB_CYC_3 = 21'h0000ff;   // 255

	// ----------------------------------------------------------------
	// Register map: indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_IDX     = 8'h17;
	localparam logic [7:0]  STAT_IDX     = 8'h18;
	localparam logic [7:0]  IRQ_STAT_IDX = 8'h20;
	localparam logic [7:0]  IRQ_MASK_IDX = 8'h21;
	localparam logic [3:0]  CTRL_RST     = 4'h0;
	localparam logic [2:0]  FLAG_RST     = 3'h0;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Synchroniser width: bus level, transmit data, overcurrent
	// ----------------------------------------------------------------
	localparam int SYNC_W = 3;
	localparam int SY_RX  = 0;
	localparam int SY_TX  = 1;
	localparam int SY_OC  = 2;

	// Control register layout, bits [3:0]
	typedef struct packed {
		logic       bus_wake_mode_sel;
		logic [1:0] short_debounce_sel;
		logic       fast_baud_en;
	} lps_ctrl_t;

	// Status flag layout, bits [2:0]
	typedef struct packed {
		logic bus_short_flag;
		logic dominant_timeout_flag;
		logic bus_wake_flag;
	} lps_flags_t;

	typedef enum logic [1:0] {WK_IDLE, WK_DOM, WK_RISE} lps_wake_st_t;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} lps_sync_st_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} lps_tmr_st_t;

endpackage : lps_pkg

// File: hw/lps_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/100ps
module lps_sync
	import lps_pkg::*;
(
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Data
	input  wire logic [SYNC_W-1:0] din,
	output logic      [SYNC_W-1:0] dout
);

	lps_sync_st_t st_r;
	lps_sync_st_t st_nxt;

	// First stage feeds only the second
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
	end

	// Reset to recessive and idle levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '{s1: 3'h3, s2: 3'h3};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.s2;

endmodule : lps_sync

// File: hw/lps_timer.sv
// Duration timer: counts ticks while run holds, expires beyond a limit
`timescale 1ns/100ps
module lps_timer
	import lps_pkg::*;
(
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Control
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] limit,
	// Result
	output logic                  expired
);

	lps_tmr_st_t st_r;
	lps_tmr_st_t st_nxt;

	// Restart whenever the condition drops; stop once past the limit
	always_comb begin
		st_nxt = st_r;
		if (!run) begin
			st_nxt.cnt = '0;
		end else if (tick && !expired) begin
			st_nxt.cnt = st_r.cnt + 21'h000001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '{cnt: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Longer than the limit, so one past it
	assign expired = run && (st_r.cnt > limit);

endmodule : lps_timer

// File: testbench/lps_assertions.sv
// Port-level assertion checker for the bus physical-layer supervisor
`timescale 1ns/100ps
module lps_chk
	import lps_pkg::*;
#(
	parameter int unsigned WAKE_CYC = 20,
	parameter int unsigned DTO_LIM  = 2000
)(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Bus pins and mode
	input wire logic        bus_rx,
	input wire logic        tx_overcurrent,
	input wire logic        tx_out,
	input wire logic        tx_power_en,
	input wire logic        fast_baud_en,
	input wire logic        sleep_req
);
	logic [11:0] sc_r;
	logic [20:0] dc_r;
	logic        wq_r;

	// Run lengths of the short and own-dominant conditions, control write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sc_r <= '0;
			dc_r <= '0;
			wq_r <= 1'b0;
		end else begin
			sc_r <= (tx_power_en && !tx_out && bus_rx && tx_overcurrent) ? sc_r + 12'h1 : '0;
			dc_r <= !tx_out ? dc_r + 21'h1 : '0;
			wq_r <= hsel && hready && htrans[1] && hwrite && haddr == {22'h0, CTRL_IDX, 2'h0};
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_ZERO_WAIT_OKAY: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or erred");
	AST_SLEEP_TX_OFF: assert property ($rose(sleep_req) |-> ##[1:2] !tx_power_en)
		else $error("transmitter powered in sleep");
	AST_TX_ONLY_POWERED: assert property ($fell(tx_out) |-> tx_power_en)
		else $error("dominant driven while unpowered");
	AST_UNPOWERED_IDLE: assert property (!tx_power_en && !$past(tx_power_en) |-> tx_out)
		else $error("unpowered driver not recessive");
	AST_FAST_BAUD: assert property (wq_r |=> fast_baud_en == $past(hwdata[0]))
		else $error("fast baud pin not following control");
	AST_SHORT_BOUND: assert property (sc_r <= 12'h514)
		else $error("short not caught in debounce span");
	AST_DTO_BOUND: assert property (dc_r <= DTO_LIM + 4)
		else $error("dominant timeout missed");
	AST_DROP_CAUSE: assert property ($fell(tx_power_en) |->
		$past(sleep_req) || $past(sc_r) > 12'h1d6 || $past(dc_r) >= DTO_LIM - 2)
		else $error("transmitter dropped without cause");
endmodule : lps_chk

bind lps_top lps_chk #(.WAKE_CYC(WAKE_CYC), .DTO_LIM(DTO_LIM)) lps_chk_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .bus_rx(bus_rx), .tx_overcurrent(tx_overcurrent), .tx_out(tx_out),
	.tx_power_en(tx_power_en), .fast_baud_en(fast_baud_en), .sleep_req(sleep_req));

// File: testbench/lps_bus_node.sv
// Single-wire bus with a peer node and fault injection
`timescale 1ns/100ps
module lps_bus_node (
	// Device side
	input  wire logic       tx_out,
	input  wire logic       tx_power_en,
	// Fault: 0 none, 1 short to supply, 2 overcurrent on low bus, 3 stuck high only
	input  wire logic [1:0] fault,
	input  wire logic       peer_dom,
	// Receiver side
	output logic            bus_rx,
	output logic            tx_overcurrent
);
	logic drv_dom;

	// Wired-AND with pull-up: a released line reads recessive
	assign drv_dom        = tx_power_en && !tx_out;
	assign bus_rx         = fault[0] ? 1'b1 : !(drv_dom || peer_dom);
	// Overcurrent only while our driver pulls against a fault
	assign tx_overcurrent = drv_dom && (fault == 2'h1 || fault == 2'h2);
endmodule : lps_bus_node

// File: testbench/test_lin_phy_supervisor.sv
// Self-checking testbench for the bus physical-layer supervisor
`timescale 1ns/100ps
module test_lin_phy_supervisor
	import lps_pkg::*;
;
	// ----------------------------------------------------------------
	// Set-up
	// ----------------------------------------------------------------
	localparam int unsigned WK     = 20;
	localparam int unsigned DTO    = 2000;   // Above longest debounce so shorts win
	localparam logic [31:0] A_CTRL = {22'h0, CTRL_IDX, 2'h0};
	localparam logic [31:0] A_STAT = {22'h0, STAT_IDX, 2'h0};
	localparam logic [31:0] A_ISTA = {22'h0, IRQ_STAT_IDX, 2'h0};
	localparam logic [31:0] A_IMSK = {22'h0, IRQ_MASK_IDX, 2'h0};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, fault;
	logic [2:0]  hsize;
	logic        bus_rx, tx_data, tx_overcurrent, tx_out, tx_power_en, fast_baud_en;
	logic        sleep_req, peer_dom;
	int          n_mismatch, check_count;

	lps_top #(.WAKE_CYC(WK), .DTO_LIM(DTO)) lps_top_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .bus_rx(bus_rx), .tx_data(tx_data), .tx_overcurrent(tx_overcurrent),
		.tx_out(tx_out), .tx_power_en(tx_power_en), .fast_baud_en(fast_baud_en),
		.sleep_req(sleep_req), .irq(irq));
	lps_bus_node lps_bus_node_i (.tx_out(tx_out), .tx_power_en(tx_power_en), .fault(fault),
		.peer_dom(peer_dom), .bus_rx(bus_rx), .tx_overcurrent(tx_overcurrent));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One single transfer; htrans goes idle in the data phase so back-to-back calls never clash
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr  <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask : rdchk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		chk(tx_power_en, 1'b1, "awake power");
		rdchk(A_STAT, 32'h0, "stat reset");
		ahb(1'b1, A_CTRL, 32'hffff_ffff);
		rdchk(A_CTRL, 32'hf, "ctrl mask");
		chk(fast_baud_en, 1'b1, "fast on");
		ahb(1'b1, 32'h400, 32'h0);
		rdchk(32'h400, 32'h0, "unmapped");
		ahb(1'b1, A_CTRL, 32'h0);
		ahb(1'b1, A_IMSK, 32'h0);
		rdchk(A_CTRL, 32'h0, "ctrl clear");
		chk(fast_baud_en, 1'b0, "fast off");
		$display("regs done");
	endtask : t_regs

	task automatic t_wake(input logic md);
		ahb(1'b1, A_CTRL, {28'h0, md, 3'h0});
		sleep_req <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(tx_power_en, 1'b0, "asleep");
		peer_dom <= 1'b1;
		repeat (WK - 8) @(posedge hclk);
		peer_dom <= 1'b0;
		repeat (12) @(posedge hclk);
		chk(tx_power_en, 1'b0, "brief low");
		peer_dom <= 1'b1;
		repeat (WK + 8) @(posedge hclk);
		chk(tx_power_en, !md, "long low");
		peer_dom <= 1'b0;
		repeat (6) @(posedge hclk);
		chk(tx_power_en, 1'b1, "woken");
		rdchk(A_STAT, 32'h1, "wake flag");
		rdchk(A_ISTA, 32'h1, "wake irq status");
		ahb(1'b1, A_STAT, 32'h0);
		rdchk(A_STAT, 32'h1, "write zero");
		ahb(1'b1, A_STAT, 32'h1);
		rdchk(A_STAT, 32'h0, "wake clear");
		sleep_req <= 1'b0;
		$display("wake mode %0d done", md);
	endtask : t_wake

	task automatic t_half();
		ahb(1'b1, A_CTRL, 32'h0);
		for (int f = 2; f < 4; f++) begin
			fault   <= f[1:0];
			tx_data <= 1'b0;
			repeat (560) @(posedge hclk);
			chk(tx_power_en, 1'b1, "half fault");
			tx_data <= 1'b1;
			repeat (4) @(posedge hclk);
		end
		fault <= 2'h0;
		rdchk(A_STAT, 32'h0, "no short");
		$display("half faults done");
	endtask : t_half

	task automatic t_short();
		int lim [4] = '{96, 128, 192, 255};
		ahb(1'b1, A_IMSK, 32'h4);
		for (int s = 0; s < 4; s++) begin
			ahb(1'b1, A_CTRL, {29'h0, s[1:0], 1'b0});
			fault   <= 2'h1;
			tx_data <= 1'b0;
			repeat (lim[s] * 5 - 8) @(posedge hclk);
			chk(tx_power_en, 1'b1, "debounce early");
			repeat (30) @(posedge hclk);
			chk({tx_power_en, tx_out, irq}, 3'b011, "short off");
			tx_data <= 1'b1;
			fault   <= 2'h0;
			rdchk(A_STAT, 32'h4, "short flag");
			rdchk(A_ISTA, 32'h4, "short irq status");
			ahb(1'b1, A_STAT, 32'h4);
			chk(irq, 1'b0, "irq cleared");
			rdchk(A_STAT, 32'h0, "short clear");
			chk(tx_power_en, 1'b1, "power back");
		end
		$display("short done");
	endtask : t_short

	// Masked event: flag and status set, interrupt line stays low
	task automatic t_dto();
		ahb(1'b1, A_IMSK, 32'h0);
		tx_data <= 1'b0;
		repeat (DTO - 10) @(posedge hclk);
		chk(tx_power_en, 1'b1, "timeout early");
		repeat (20) @(posedge hclk);
		chk({tx_power_en, tx_out, irq}, 3'b010, "timeout off");
		tx_data <= 1'b1;
		rdchk(A_STAT, 32'h2, "timeout flag");
		rdchk(A_ISTA, 32'h2, "timeout irq status");
		ahb(1'b1, A_STAT, 32'h2);
		rdchk(A_STAT, 32'h0, "timeout clear");
		$display("timeout done");
	endtask : t_dto

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		{hresetn, hwrite, sleep_req, peer_dom, fault, htrans} = '0;
		{hsel, tx_data, hsize, haddr, hwdata} = {2'b11, 3'h2, 64'h0};
		n_mismatch = 0;
		check_count = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		// Outputs first move at the edge after release; sample one edge later
		repeat (2) @(posedge hclk);
		t_regs();
		t_wake(1'b0);
		t_wake(1'b1);
		t_half();
		t_short();
		t_dto();
		final_report();
	end

	// All scenarios need under 9000 cycles; allow about twice that
	initial begin
		#(8 * 20000);
		n_mismatch++;
		final_report();
	end
endmodule : test_lin_phy_supervisor
